// ===== hdl/srp_chan.sv
`timescale 1ns/100ps
`default_nettype none
module srp_chan
  import srp_pkg::*;
#(
  parameter int TRIM_SHIFT = SRP_T_TRIM_SHIFT
)
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  srp_chan_if.chan ch
);
  logic signed [17:0] trim_ext;
  logic signed [17:0] sum;
  logic [15:0] adj_nxt;
  logic [15:0] result_r;
  logic [7:0] peak_r;

  // trim is two's complement, its lsb lands on bit TRIM_SHIFT of the code
  always_comb
  begin
    trim_ext = $signed({{10{ch.trim[7]}}, ch.trim}) <<< TRIM_SHIFT;
    sum = $signed({2'b00, ch.raw, 2'b00}) + trim_ext;
    // clamp instead of wrapping so a trim never flips hot into cold
    if (sum < 0)
      adj_nxt = SRP_RST_WORD;
    else if (sum > $signed({2'b00, SRP_RES_MAX}))
      adj_nxt = SRP_RES_MAX;
    else
      adj_nxt = sum[15:0] & SRP_RES_MAX;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      result_r <= SRP_RST_WORD;
    else if (ch.clr)
      result_r <= SRP_RST_WORD;
    else if (ch.conv_valid)
      result_r <= adj_nxt;
  end

  // peak byte shares the scale of the result upper byte
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      peak_r <= SRP_RST_BYTE;
    else if (ch.clr)
      peak_r <= SRP_RST_BYTE;
    else if (ch.peak_wr)
      peak_r <= ch.peak_wdata;
    else if (ch.conv_valid && ch.host_req && !ch.auto_on && adj_nxt[15:8] > peak_r)
      peak_r <= adj_nxt[15:8];
  end

  assign ch.result = result_r;
  assign ch.peak = peak_r;
endmodule
`default_nettype wire

// ===== hdl/srp_postproc.sv
`timescale 1ns/100ps
`default_nettype none
module srp_postproc
  import srp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_temp_done,
  input wire logic [13:0] i_temp_raw,
  input wire logic i_hum_done,
  input wire logic [13:0] i_hum_raw,
  input wire logic i_host_req,
  input wire logic [3:0] i_limit_hit,
  output logic [15:0] o_temp_result,
  output logic [15:0] o_hum_result,
  output logic [7:0] o_temp_low_limit,
  output logic [2:0] o_auto_sample_rate,
  output logic [3:0] o_cfg_misc,
  output logic [4:0] o_src_pending,
  output logic o_nvm_reload
);
  srp_rst_state_type state_r;
  srp_rst_state_type state_nxt;
  logic soft_clr;
  logic [7:0] irq_en_r;
  logic [7:0] trim_t_r;
  logic [7:0] trim_h_r;
  logic [7:0] tlow_r;
  logic [6:0] cfg_r;
  logic [4:0] flag_r;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  logic [4:0] pend_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic auto_on;
  logic rd_status;
  logic rd_result;

  srp_chan_if ch_t ();
  srp_chan_if ch_h ();

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
    is_addr = (a == b);
  endfunction

  function automatic logic wr_to(input logic [7:0] a);
    wr_to = i_reg_wr && is_addr(i_reg_addr, a) && state_r == SRP_RUN;
  endfunction

  // soft reset: one clearing cycle, then the request bit drops by itself
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      SRP_RUN:
      begin
        if (wr_to(SRP_A_CONFIG) && i_reg_wdata[SRP_B_SWRST])
          state_nxt = SRP_CLEAR;
      end
      SRP_CLEAR:
      begin
        state_nxt = SRP_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      state_r <= SRP_RUN;
    else
      state_r <= state_nxt;
  end

  assign soft_clr = (state_r == SRP_CLEAR);
  assign o_nvm_reload = soft_clr;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      irq_en_r <= SRP_RST_BYTE;
    else if (soft_clr)
      irq_en_r <= SRP_RST_BYTE;
    else if (wr_to(SRP_A_IRQ_EN))
      irq_en_r <= i_reg_wdata & SRP_SRC_MASK;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      trim_t_r <= SRP_RST_BYTE;
    else if (soft_clr)
      trim_t_r <= SRP_RST_BYTE;
    else if (wr_to(SRP_A_TRIM_T))
      trim_t_r <= i_reg_wdata;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      trim_h_r <= SRP_RST_BYTE;
    else if (soft_clr)
      trim_h_r <= SRP_RST_BYTE;
    else if (wr_to(SRP_A_TRIM_H))
      trim_h_r <= i_reg_wdata;
  end

  // stored raw; the comparator outside reads it on the peak-byte scale
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      tlow_r <= SRP_RST_BYTE;
    else if (soft_clr)
      tlow_r <= SRP_RST_BYTE;
    else if (wr_to(SRP_A_TLOW))
      tlow_r <= i_reg_wdata;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      cfg_r <= 7'h00;
    else if (soft_clr)
      cfg_r <= 7'h00;
    else if (wr_to(SRP_A_CONFIG))
      cfg_r <= i_reg_wdata[6:0];
  end

  assign o_auto_sample_rate = cfg_r[SRP_F_AUTO_HI:SRP_F_AUTO_LO];
  assign auto_on = (o_auto_sample_rate != SRP_AUTO_OFF);
  assign o_cfg_misc = cfg_r[3:0];
  assign o_temp_low_limit = tlow_r;

  // channel wiring
  assign ch_t.conv_valid = i_temp_done;
  assign ch_t.host_req = i_host_req;
  assign ch_t.auto_on = auto_on;
  assign ch_t.clr = soft_clr;
  assign ch_t.raw = i_temp_raw;
  assign ch_t.trim = trim_t_r;
  assign ch_t.peak_wr = wr_to(SRP_A_PEAK_T);
  assign ch_t.peak_wdata = i_reg_wdata;
  assign ch_h.conv_valid = i_hum_done;
  assign ch_h.host_req = i_host_req;
  assign ch_h.auto_on = auto_on;
  assign ch_h.clr = soft_clr;
  assign ch_h.raw = i_hum_raw;
  assign ch_h.trim = trim_h_r;
  assign ch_h.peak_wr = wr_to(SRP_A_PEAK_H);
  assign ch_h.peak_wdata = i_reg_wdata;

  srp_chan #(.TRIM_SHIFT(SRP_T_TRIM_SHIFT)) u_temp (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .ch(ch_t)
  );

  srp_chan #(.TRIM_SHIFT(SRP_H_TRIM_SHIFT)) u_hum (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .ch(ch_h)
  );

  assign o_temp_result = ch_t.result;
  assign o_hum_result = ch_h.result;

  // status flags: a read clears, but a same-cycle event still lands
  assign rd_status = i_reg_rd && is_addr(i_reg_addr, SRP_A_STATUS);
  assign rd_result = i_reg_rd && i_reg_addr <= SRP_A_HUM_HI;
  assign flag_set = {i_temp_done | i_hum_done, i_limit_hit};
  assign flag_clr = {rd_status | rd_result, {4{rd_status}}};

  genvar gi;
  generate
    for (gi = 0; gi < SRP_NSRC; gi++)
    begin : g_flag
      always_ff @(posedge i_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
          flag_r[gi] <= 1'b0;
        else if (flag_set[gi])
          flag_r[gi] <= 1'b1;
        else if (soft_clr || flag_clr[gi])
          flag_r[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      pend_r <= 5'h00;
    else
      pend_r <= flag_r & irq_en_r[7:SRP_SRC_LSB];
  end

  assign o_src_pending = pend_r;

  always_comb
  begin
    rdata_nxt = SRP_RST_BYTE;
    unique case (i_reg_addr)
      SRP_A_TEMP_LO: rdata_nxt = o_temp_result[7:0];
      SRP_A_TEMP_HI: rdata_nxt = o_temp_result[15:8];
      SRP_A_HUM_LO: rdata_nxt = o_hum_result[7:0];
      SRP_A_HUM_HI: rdata_nxt = o_hum_result[15:8];
      SRP_A_STATUS: rdata_nxt = {flag_r, 3'b000};
      SRP_A_PEAK_T: rdata_nxt = ch_t.peak;
      SRP_A_PEAK_H: rdata_nxt = ch_h.peak;
      SRP_A_IRQ_EN: rdata_nxt = irq_en_r;
      SRP_A_TRIM_T: rdata_nxt = trim_t_r;
      SRP_A_TRIM_H: rdata_nxt = trim_h_r;
      SRP_A_TLOW: rdata_nxt = tlow_r;
      SRP_A_CONFIG: rdata_nxt = {soft_clr, cfg_r};
      default: rdata_nxt = SRP_RST_BYTE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      rdata_r <= SRP_RST_BYTE;
    else if (i_reg_rd)
      rdata_r <= rdata_nxt;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      rvalid_r <= 1'b0;
    else
      rvalid_r <= i_reg_rd;
  end

  assign o_reg_rdata = rdata_r;
  assign o_reg_rvalid = rvalid_r;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  logic t_upd;
  assign t_upd = i_temp_done && i_host_req && !auto_on && !soft_clr
    && !ch_t.peak_wr;

  peak_track_a: assert property (
    t_upd |=> ch_t.peak >= o_temp_result[15:8])
    else $error("temperature peak below latest result");

  peak_hold_a: assert property (
    !soft_clr && !ch_h.peak_wr |=> ch_h.peak >= $past(ch_h.peak))
    else $error("humidity peak dropped without write");

  soft_clear_a: assert property (
    wr_to(SRP_A_CONFIG) && i_reg_wdata[SRP_B_SWRST]
    |=> soft_clr ##1 (!soft_clr && ch_t.peak == 8'h00 && ch_h.peak == 8'h00))
    else $error("soft reset did not clear peaks");

  auto_block_a: assert property (
    auto_on && !soft_clr && !ch_t.peak_wr |=> $stable(ch_t.peak))
    else $error("temperature peak moved in auto mode");

  gate_map_a: assert property (
    ##1 o_src_pending == ($past(flag_r) & $past(irq_en_r[7:3])))
    else $error("pending sources not gated by enables");

  trim_zero_a: assert property (
    i_temp_done && trim_t_r == 8'h00 && !soft_clr
    |=> o_temp_result == {$past(i_temp_raw), 2'b00})
    else $error("zero trim altered temperature");

  trim_one_a: assert property (
    i_hum_done && trim_h_r == 8'h01 && !soft_clr && i_hum_raw < 14'h3e00
    |=> o_hum_result == {$past(i_hum_raw), 2'b00} + 16'h0080)
    else $error("humidity trim lsb misaligned");

  lsb_zero_a: assert property (
    o_temp_result[1:0] == 2'b00 && o_hum_result[1:0] == 2'b00)
    else $error("result low bits not zero");

  done_set_a: assert property (
    i_temp_done || i_hum_done |=> flag_r[4])
    else $error("done flag not set");

  done_clear_a: assert property (
    rd_status && !i_temp_done && !i_hum_done |=> !flag_r[4] && o_reg_rvalid)
    else $error("done flag not cleared by read");

  en_reserved_a: assert property (
    wr_to(SRP_A_IRQ_EN) |=> irq_en_r == ($past(i_reg_wdata) & 8'hf8))
    else $error("enable reserved bits stored");

  trim_neg_a: assert property (
    i_temp_done && trim_t_r == 8'hff && !soft_clr && i_temp_raw > 14'h000f
    |=> o_temp_result == {$past(i_temp_raw), 2'b00} - 16'h0040)
    else $error("temperature trim sign weight wrong");

  cfg_store_a: assert property (
    wr_to(SRP_A_CONFIG)
    |=> {1'b0, o_auto_sample_rate, o_cfg_misc} == ($past(i_reg_wdata) & 8'h7f))
    else $error("config fields not stored");

  soft_done_a: assert property (
    soft_clr |=> !soft_clr && irq_en_r == 8'h00 && trim_t_r == 8'h00 && trim_h_r == 8'h00)
    else $error("soft reset left registers set");

  tlow_store_a: assert property (
    wr_to(SRP_A_TLOW) |=> o_temp_low_limit == $past(i_reg_wdata))
    else $error("low temperature limit not stored");

  soft_cov_c: cover property (soft_clr ##1 !soft_clr);
  peak_cov_c: cover property (t_upd ##1 ch_t.peak != $past(ch_t.peak));
  clear_cov_c: cover property (flag_r[4] && rd_status ##1 !flag_r[4]);
  race_cov_c: cover property (rd_status && i_temp_done);
endmodule
`default_nettype wire

// ===== inc/srp_chan_if.sv
`timescale 1ns/100ps
`default_nettype none
interface srp_chan_if;
  logic conv_valid;
  logic host_req;
  logic auto_on;
  logic clr;
  logic [13:0] raw;
  logic [7:0] trim;
  logic peak_wr;
  logic [7:0] peak_wdata;
  logic [15:0] result;
  logic [7:0] peak;
  modport ctl (
    output conv_valid, host_req, auto_on, clr, raw, trim, peak_wr, peak_wdata,
    input result, peak
  );
  modport chan (
    input conv_valid, host_req, auto_on, clr, raw, trim, peak_wr, peak_wdata,
    output result, peak
  );
endinterface
`default_nettype wire

// ===== inc/srp_pkg.sv
`default_nettype none
package srp_pkg;
  // register offsets
  localparam logic [7:0] SRP_A_TEMP_LO = 8'h00;
  localparam logic [7:0] SRP_A_TEMP_HI = 8'h01;
  localparam logic [7:0] SRP_A_HUM_LO = 8'h02;
  localparam logic [7:0] SRP_A_HUM_HI = 8'h03;
  localparam logic [7:0] SRP_A_STATUS = 8'h04;
  localparam logic [7:0] SRP_A_PEAK_T = 8'h05;
  localparam logic [7:0] SRP_A_PEAK_H = 8'h06;
  localparam logic [7:0] SRP_A_IRQ_EN = 8'h07;
  localparam logic [7:0] SRP_A_TRIM_T = 8'h08;
  localparam logic [7:0] SRP_A_TRIM_H = 8'h09;
  localparam logic [7:0] SRP_A_TLOW = 8'h0a;
  localparam logic [7:0] SRP_A_CONFIG = 8'h0e;
  // status and enable layout: bits 7..3 are done, t-high, t-low, h-high, h-low
  localparam int SRP_SRC_LSB = 3;
  localparam int SRP_NSRC = 5;
  localparam logic [7:0] SRP_SRC_MASK = 8'hf8;
  // config register fields
  localparam int SRP_B_SWRST = 7;
  localparam int SRP_F_AUTO_HI = 6;
  localparam int SRP_F_AUTO_LO = 4;
  localparam logic [2:0] SRP_AUTO_OFF = 3'h0;
  // reset values
  localparam logic [7:0] SRP_RST_BYTE = 8'h00;
  localparam logic [15:0] SRP_RST_WORD = 16'h0000;
  // trim lsb position inside the 16-bit result code
  localparam int SRP_T_TRIM_SHIFT = 6;
  localparam int SRP_H_TRIM_SHIFT = 7;
  localparam logic [15:0] SRP_RES_MAX = 16'hfffc;
  typedef enum logic {SRP_RUN, SRP_CLEAR} srp_rst_state_type;
endpackage
`default_nettype wire

// ===== verif/sensor_result_postprocess_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sensor_result_postprocess_tb;
  import srp_pkg::*;
  logic clk, rst_b, wr, rd, rvalid, t_done, h_done, host, reload;
  logic [7:0] addr, wdata, rdata, tlow;
  logic [13:0] t_raw, h_raw;
  logic [3:0] hit, misc;
  logic [15:0] t_res, h_res;
  logic [2:0] rate;
  logic [4:0] pend;
  int n_fail, checked, pk_t, pk_h, tr_t, tr_h, rate_m, tt, th, rw, hq, seen;

  srp_postproc dut (.i_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_temp_done(t_done), .i_temp_raw(t_raw), .i_hum_done(h_done), .i_hum_raw(h_raw),
    .i_host_req(host), .i_limit_hit(hit), .o_temp_result(t_res), .o_hum_result(h_res),
    .o_temp_low_limit(tlow), .o_auto_sample_rate(rate), .o_cfg_misc(misc),
    .o_src_pending(pend), .o_nvm_reload(reload));
  srp_host_model u_host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_addr(addr),
    .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

  task automatic finish_test;
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input int e);
    logic [7:0] d;
    bit ok;
    u_host.rd(a, d, ok);
    if (!ok)
    begin
      n_fail++;
      finish_test();
    end
    chk({8'h00, d}, e[15:0]);
  endtask
  // trim lsb sits at weight 1<<sh of the result; sums clamp instead of wrapping
  function automatic int calc(int raw, int trim, int sh);
    int v;
    v = raw * 4 + (trim > 127 ? trim - 256 : trim) * (1 << sh);
    if (v < 0)
      v = 0;
    if (v > 65532)
      v = 65532;
    return v;
  endfunction
  task automatic conv(input bit hum, input int raw, input int hreq);
    int r;
    r = calc(raw, hum ? tr_h : tr_t, hum ? 7 : 6);
    @(negedge clk);
    host = hreq[0];
    t_raw = raw[13:0];
    h_raw = raw[13:0];
    t_done = !hum;
    h_done = hum;
    @(negedge clk);
    t_done = 1'b0;
    h_done = 1'b0;
    if (hreq != 0 && rate_m == 0)
    begin
      if (hum && (r >> 8) > pk_h)
        pk_h = r >> 8;
      if (!hum && (r >> 8) > pk_t)
        pk_t = r >> 8;
    end
    chk(hum ? h_res : t_res, r[15:0]);
  endtask
  task automatic peaks;
    rchk(SRP_A_PEAK_T, pk_t);
    rchk(SRP_A_PEAK_H, pk_h);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial
  begin
    {rst_b, t_done, h_done, host, hit, t_raw, h_raw} = '0;
    {n_fail, checked, pk_t, pk_h, tr_t, tr_h, rate_m, seen} = '0;
    void'($urandom(26913));
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    for (int a = 5; a <= 9; a++)
      rchk(a[7:0], 0);
    rchk(8'h40, 0);
    u_host.wr(SRP_A_IRQ_EN, 8'hff);
    rchk(SRP_A_IRQ_EN, 8'hf8);
    // auto sampling first, while both peaks are still zero
    u_host.wr(SRP_A_CONFIG, 8'h1f);
    rate_m = 1;
    chk({9'h000, rate, misc}, 16'h001f);
    conv(0, 14'h3fff, 1);
    conv(1, 14'h3fff, 1);
    peaks();
    u_host.wr(SRP_A_CONFIG, 8'h00);
    rate_m = 0;
    conv(0, 14'h2000, 0);
    peaks();
    for (int i = 0; i < 24; i++)
    begin
      tt = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : (i == 2) ? 8'hff : $urandom % 256;
      th = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : (i == 2) ? 8'h01 : $urandom % 256;
      rw = (i == 0) ? 0 : (i == 1) ? 14'h3fff : (i == 2) ? 14'h2345 : $urandom % 16384;
      hq = (i < 2) ? 1 : $urandom % 2;
      u_host.wr(SRP_A_TRIM_T, tt[7:0]);
      u_host.wr(SRP_A_TRIM_H, th[7:0]);
      tr_t = tt;
      tr_h = th;
      conv(0, rw, hq);
      conv(1, (i == 2) ? 14'h1000 : $urandom % 16384, hq);
      peaks();
    end
    for (int s = 0; s < 5; s++)
    begin
      u_host.wr(SRP_A_IRQ_EN, 8'h08 << s);
      conv(0, $urandom % 16384, 1);
      @(negedge clk);
      hit = 4'hf;
      @(negedge clk);
      hit = 4'h0;
      repeat (2) @(negedge clk);
      chk({11'h000, pend}, 16'h0001 << s);
      rchk(SRP_A_STATUS, 8'hf8);
      rchk(SRP_A_STATUS, 8'h00);
    end
    u_host.wr(SRP_A_TLOW, 8'h5a);
    chk({8'h00, tlow}, 16'h005a);
    u_host.wr(SRP_A_PEAK_T, 8'hc3);
    rchk(SRP_A_PEAK_T, 8'hc3);
    u_host.wr(SRP_A_PEAK_H, 8'h3c);
    rchk(SRP_A_PEAK_H, 8'h3c);
    u_host.wr(SRP_A_CONFIG, 8'h80);
    for (int k = 0; k < 4; k++)
    begin
      if (reload === 1'b1)
        seen = 1;
      @(negedge clk);
    end
    chk(seen[15:0], 16'h0001);
    {pk_t, pk_h, tr_t, tr_h} = '0;
    for (int a = 0; a <= 10; a++)
      rchk(a[7:0], 0);
    rchk(SRP_A_CONFIG, 0);
    conv(0, 14'h1234, 1);
    peaks();
    rchk(SRP_A_TEMP_LO, 8'hd0);
    rchk(SRP_A_TEMP_HI, 8'h48);
    rchk(SRP_A_STATUS, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire

// ===== verif/srp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module srp_host_model
(
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  initial
  begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // strobes move on the falling edge so the device samples settled values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
  endtask
  // rvalid is a one-cycle pulse, so it is looked at every falling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    for (int k = 0; k < 4 && !ok; k++)
    begin
      if (i_rvalid === 1'b1)
      begin
        d = i_rdata;
        ok = 1'b1;
      end
      else
        @(negedge i_clk);
    end
  endtask
endmodule
`default_nettype wire
